// ===== rtl/rvr_pkg.sv
// Function
// - with preset bit 7 clear, a written code applies at once.
// - with preset bit set, code is held and applied at power-down instead.
// - go bit 0 ramps the core buck to its target.
// - go bit 1 ramps the processor buck to its target.
// - go bit 2 ramps the memory buck to its target.
// - go bit 3 ramps the second LDO to its target.
// - go bit 4 ramps the third LDO to its target.
// - each go bit self-clears once its rail reaches the target.
// - writes to a ramping rail's register are ignored; core go blocks processor register.
// - a buck ramping under its go bit is forced to PWM.
// - second and third LDO go bits ignored while their preset bit is set.
// - supply bit 5 closes the peripheral switch under sequencer control.
// - supply bit 6 closes the memory switch under sequencer control.
// - lock bit 7 clear lets host write all voltage codes.
// - lock set rejects code writes; enables, ramps and sequencing still work.
// Constants and carriers of the regulator ramp control block.
// Assumes one 10 MHz clock domain and an APB master.
`default_nettype none
package rvr_pkg;
  localparam int          ADDR_W     = 12;
  localparam int          CODE_W     = 6;
  localparam int          NRAIL      = 5;
  localparam logic [7:0]  IDX_LTEN   = 8'h3B;
  localparam logic [7:0]  IDX_SUPPLY = 8'h3C;
  localparam logic [7:0]  IDX_RAIL0  = 8'h30;
  localparam int          EN_BIT     = 6;
  localparam int          PRESET_BIT = 7;
  localparam int          RAIL_CORE  = 0;
  localparam int          RAIL_PROC  = 1;
  localparam int          RAIL_LSEC  = 3;
  localparam logic [5:0]  CODE_MAX   = 6'h30;
  localparam logic [11:0] MV_BASE    = 12'h4B0;
  localparam logic [11:0] MV_STEP    = 12'h032;
  localparam int          CLK_NS     = 100;
  localparam int          STEP_NS    = 1000;
  localparam int          STEP_CYC   = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  LTEN_RST   = 8'h00;
  localparam logic [7:0]  SUPPLY_RST = 8'h00;
  localparam logic [7:0]  RAIL_RST   = 8'h00;

  typedef struct packed {
    logic       preset;
    logic       en;
    logic [5:0] code;
  } rvr_ldo_ctrl_t;

  typedef struct packed {
    logic       lock;
    logic       msw;
    logic       psw;
    logic [4:0] go;
  } rvr_supply_t;

  typedef struct packed {
    logic       go;
    logic [5:0] target;
  } rvr_ramp_t;

  typedef struct packed {
    logic        on;
    logic [5:0]  code;
    logic [11:0] mv;
  } rvr_ldo_ten_out_t;
endpackage
`default_nettype wire

// ===== rtl/rvr_ramp.sv
// One rail ramp engine: steps the present code toward the target.
// Assumes go holds until done is seen by the owner.
`default_nettype none
module rvr_ramp #(
  parameter int STEP_CYC = rvr_pkg::STEP_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Ramp request and state
  input  wire rvr_pkg::rvr_ramp_t ramp,
  output logic [5:0]             present,
  output logic                   done
);
  localparam int CNT_W = $clog2(STEP_CYC + 1);

  if (STEP_CYC < 1) begin : g_chk
    $error("STEP_CYC must be at least 1");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [5:0]       present;
  } rvr_ramp_state_t;

  rvr_ramp_state_t s;
  rvr_ramp_state_t next_s;

  assign present = s.present;
  assign done    = ramp.go && (s.present == ramp.target);

  always_comb begin
    next_s = s;
    if (ramp.go && !done) begin
      if (s.cnt == CNT_W'(STEP_CYC - 1)) begin
        next_s.cnt = '0;
        // One code per step interval
        if (s.present < ramp.target) begin
          next_s.present = s.present + 6'h01;
        end else begin
          next_s.present = s.present - 6'h01;
        end
      end else begin
        next_s.cnt = s.cnt + CNT_W'(1);
      end
    end else begin
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{cnt: '0, present: rvr_pkg::RAIL_RST[5:0]};
    end else begin
      s <= next_s;
    end
  end

  property p_step;
    @(posedge pclk) disable iff (!presetn)
    $changed(s.present) |-> $past(ramp.go) && ($past(s.cnt) == CNT_W'(STEP_CYC - 1));
  endproperty
  a_step: assert property (p_step) else $error("present code moved off its step");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    !ramp.go |=> $stable(s.present);
  endproperty
  a_hold: assert property (p_hold) else $error("present code moved without go");
endmodule
`default_nettype wire

// ===== rtl/rvr_regs.sv
// Register bank and ramp control of the regulator block, APB slave.
// Assumes the sequencer inputs are synchronous to pclk.
//
// The implementer's own choice: the APB slave port.
`default_nettype none
module rvr_regs #(
  parameter int STEP_CYC = rvr_pkg::STEP_CYC
) (
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [rvr_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Sequencer
  input  wire logic                         power_down,
  input  wire logic                         seq_periph_on,
  input  wire logic                         seq_mem_on,
  // Regulator controls
  output logic [rvr_pkg::NRAIL-1:0][5:0]    rail_code,
  output logic [2:0]                        buck_pwm_force,
  output rvr_pkg::rvr_ldo_ten_out_t         ldo_ten_out,
  output logic                              periph_switch_pin,
  output logic                              memory_switch_pin
);
  localparam int NRAIL = rvr_pkg::NRAIL;

  if (STEP_CYC < 1) begin : g_chk
    $error("STEP_CYC must be at least 1");
  end

  typedef struct packed {
    rvr_pkg::rvr_ldo_ctrl_t         ldo_ten;
    rvr_pkg::rvr_supply_t           sup;
    logic [NRAIL-1:0][7:0]          rail;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
    rvr_pkg::rvr_ldo_ten_out_t      l10o;
    logic                           psw;
    logic                           msw;
    logic [2:0]                     pwm;
  } rvr_state_t;

  localparam rvr_state_t RST_S = '{
    ldo_ten: rvr_pkg::LTEN_RST,
    sup:     rvr_pkg::SUPPLY_RST,
    rail:    {NRAIL{rvr_pkg::RAIL_RST}},
    l10o:    '{on: 1'b0, code: rvr_pkg::LTEN_RST[5:0], mv: rvr_pkg::MV_BASE},
    default: '0
  };

  function automatic logic [5:0] sat_code(input logic [5:0] c);
    sat_code = (c > rvr_pkg::CODE_MAX) ? rvr_pkg::CODE_MAX : c;
  endfunction

  function automatic logic [11:0] code_mv(input logic [5:0] c);
    code_mv = rvr_pkg::MV_BASE + 12'({6'h00, c} * rvr_pkg::MV_STEP);
  endfunction

  rvr_state_t        s;
  rvr_state_t        next_s;
  logic [7:0]        idx;
  logic [7:0]        rofs;
  logic [2:0]        ridx;
  logic              in_page;
  logic              hit_l10;
  logic              hit_sup;
  logic              hit_rail;
  logic              acc;
  logic              wr;
  logic [NRAIL-1:0]  done;
  logic [NRAIL-1:0]  blocked;
  logic [NRAIL-1:0]  go_refused;

  // Ramp engines, one per rail
  for (genvar g = 0; g < NRAIL; g++) begin : g_rail
    rvr_pkg::rvr_ramp_t req;
    assign req = '{go: s.sup.go[g], target: s.rail[g][5:0]};
    rvr_ramp #(
      .STEP_CYC (STEP_CYC)
    ) rvr_ramp_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .ramp    (req),
      .present (rail_code[g]),
      .done    (done[g])
    );
  end

  assign prdata            = s.prdata;
  assign pready            = s.pready;
  assign pslverr           = s.pslverr;
  assign buck_pwm_force    = s.pwm;
  assign ldo_ten_out       = s.l10o;
  assign periph_switch_pin = s.psw;
  assign memory_switch_pin = s.msw;

  // Address decode; byte address is four times the index
  always_comb begin
    idx      = paddr[9:2];
    rofs     = idx - rvr_pkg::IDX_RAIL0;
    ridx     = rofs[2:0];
    in_page  = (paddr[rvr_pkg::ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
    hit_l10  = in_page && (idx == rvr_pkg::IDX_LTEN);
    hit_sup  = in_page && (idx == rvr_pkg::IDX_SUPPLY);
    hit_rail = in_page && (rofs < 8'(NRAIL));
    acc      = psel && penable;
    wr       = acc && pwrite && s.pready;
  end

  always_comb begin
    for (int i = 0; i < NRAIL; i++) begin
      blocked[i]    = s.sup.go[i] || (i == rvr_pkg::RAIL_PROC && s.sup.go[rvr_pkg::RAIL_CORE]);
      go_refused[i] = (i >= rvr_pkg::RAIL_LSEC) && s.rail[i][rvr_pkg::PRESET_BIT];
    end
  end

  always_comb begin
    next_s         = s;
    next_s.pready  = acc && !s.pready;
    next_s.pslverr = 1'b0;
    // Read data is captured on the same edge that raises pready
    if (acc && !s.pready) begin
      next_s.prdata  = '0;
      next_s.pslverr = !(hit_l10 || hit_sup || hit_rail);
      if (hit_l10) begin
        next_s.prdata[7:0] = s.ldo_ten;
      end else if (hit_sup) begin
        next_s.prdata[7:0] = s.sup;
      end else if (hit_rail) begin
        next_s.prdata[7:0] = s.rail[ridx];
      end
    end
    for (int i = 0; i < NRAIL; i++) begin
      next_s.sup.go[i] = s.sup.go[i] && !done[i];
    end
    if (wr && hit_l10) begin
      next_s.ldo_ten.en     = pwdata[rvr_pkg::EN_BIT];
      next_s.ldo_ten.preset = pwdata[rvr_pkg::PRESET_BIT];
      if (!s.sup.lock) begin
        next_s.ldo_ten.code = pwdata[5:0];
      end
    end
    if (wr && hit_sup) begin
      next_s.sup.lock = pwdata[7];
      next_s.sup.msw  = pwdata[6];
      next_s.sup.psw  = pwdata[5];
      // A new go beats a same-cycle completion
      for (int i = 0; i < NRAIL; i++) begin
        if (pwdata[i] && !go_refused[i]) begin
          next_s.sup.go[i] = 1'b1;
        end
      end
    end
    if (wr && hit_rail && !blocked[ridx]) begin
      next_s.rail[ridx][rvr_pkg::PRESET_BIT] = pwdata[rvr_pkg::PRESET_BIT];
      if (!s.sup.lock) begin
        next_s.rail[ridx][5:0] = pwdata[5:0];
      end
    end
    // Tenth LDO output stage
    if (!next_s.ldo_ten.preset || power_down) begin
      next_s.l10o.code = sat_code(next_s.ldo_ten.code);
    end
    next_s.l10o.on = next_s.ldo_ten.en && (!power_down || next_s.ldo_ten.preset);
    next_s.l10o.mv = code_mv(next_s.l10o.code);
    next_s.pwm     = next_s.sup.go[2:0];
    next_s.psw     = next_s.sup.psw && seq_periph_on;
    next_s.msw     = next_s.sup.msw && seq_mem_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sat;
    s.l10o.code <= rvr_pkg::CODE_MAX && s.l10o.mv == code_mv(s.l10o.code);
  endproperty
  a_sat: assert property (p_sat) else $error("tenth LDO code out of range");

  property p_en;
    !$past(power_down) |-> s.l10o.on == s.ldo_ten.en;
  endproperty
  a_en: assert property (p_en) else $error("tenth LDO enable mismatch");

  property p_immediate;
    !s.ldo_ten.preset |-> s.l10o.code == sat_code(s.ldo_ten.code);
  endproperty
  a_immediate: assert property (p_immediate) else $error("code not applied at once");

  property p_preset_hold;
    $past(s.ldo_ten.preset) && s.ldo_ten.preset && !$past(power_down) |-> $stable(s.l10o.code);
  endproperty
  a_preset_hold: assert property (p_preset_hold) else $error("preset code applied early");

  property p_go_core;
    wr && hit_sup && pwdata[0] |=> s.sup.go[0];
  endproperty
  a_go_core: assert property (p_go_core) else $error("core go not set");

  property p_go_mem;
    wr && hit_sup && pwdata[2] |=> s.sup.go[2] ##0 s.pwm[2];
  endproperty
  a_go_mem: assert property (p_go_mem) else $error("memory buck go or pwm missing");

  property p_done;
    s.sup.go[1] && done[1] && !(wr && hit_sup && pwdata[1]) |=> !s.sup.go[1];
  endproperty
  a_done: assert property (p_done) else $error("go bit not cleared at target");

  property p_block;
    wr && hit_rail && ridx == 3'(rvr_pkg::RAIL_PROC) && s.sup.go[rvr_pkg::RAIL_CORE] |=> $stable(s.rail[1]);
  endproperty
  a_block: assert property (p_block) else $error("processor register written during ramp");

  property p_pwm;
    s.pwm == s.sup.go[2:0];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm force not tied to go");

  property p_refuse;
    wr && hit_sup && s.rail[4][rvr_pkg::PRESET_BIT] && !s.sup.go[4] |=> !s.sup.go[4];
  endproperty
  a_refuse: assert property (p_refuse) else $error("third LDO go taken under preset");

  property p_psw;
    ##1 periph_switch_pin == (s.sup.psw && $past(seq_periph_on));
  endproperty
  a_psw: assert property (p_psw) else $error("peripheral switch mismatch");

  property p_lock;
    wr && s.sup.lock && (hit_rail || hit_l10) |=> $stable(s.ldo_ten.code) && $stable(s.rail[ridx][5:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("code written under lock");

  property p_apb;
    acc && !s.pready |=> s.pready ##1 !s.pready;
  endproperty
  a_apb: assert property (p_apb) else $error("pready timing wrong");

  property p_err;
    acc && !s.pready && !(hit_l10 || hit_sup || hit_rail) |=> s.pready && s.pslverr && s.prdata == '0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");

  property p_go_proc;
    wr && hit_sup && pwdata[1] |=> s.sup.go[1] ##0 s.pwm[1];
  endproperty
  a_go_proc: assert property (p_go_proc) else $error("processor buck go or pwm missing");

  property p_go_second;
    wr && hit_sup && pwdata[3] && !s.rail[3][rvr_pkg::PRESET_BIT] |=> s.sup.go[3];
  endproperty
  a_go_second: assert property (p_go_second) else $error("second LDO go not set");

  property p_go_third;
    wr && hit_sup && pwdata[4] && !s.rail[4][rvr_pkg::PRESET_BIT] |=> s.sup.go[4];
  endproperty
  a_go_third: assert property (p_go_third) else $error("third LDO go not set");

  property p_refuse_second;
    wr && hit_sup && s.rail[3][rvr_pkg::PRESET_BIT] && !s.sup.go[3] |=> !s.sup.go[3];
  endproperty
  a_refuse_second: assert property (p_refuse_second) else $error("second LDO go taken under preset");

  property p_own_block;
    wr && hit_rail && blocked[ridx] |=> $stable(s.rail);
  endproperty
  a_own_block: assert property (p_own_block) else $error("rail register written during ramp");

  property p_msw;
    ##1 memory_switch_pin == (s.sup.msw && $past(seq_mem_on));
  endproperty
  a_msw: assert property (p_msw) else $error("memory switch mismatch");

  property p_unlock;
    wr && hit_l10 && !s.sup.lock |=> s.ldo_ten.code == $past(pwdata[5:0]);
  endproperty
  a_unlock: assert property (p_unlock) else $error("code write lost while unlocked");

  property p_pd_apply;
    power_down |=> s.l10o.code == sat_code(s.ldo_ten.code);
  endproperty
  a_pd_apply: assert property (p_pd_apply) else $error("preset code not applied at power-down");
endmodule
`default_nettype wire

// ===== test/regulator_voltage_ramp_control_test.sv
// Self-checking bench for the regulator ramp control register bank.
// Assumes rvr_pkg and rvr_regs are compiled first; bench acts as APB master.
`default_nettype none
module regulator_voltage_ramp_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 2;

  logic                                pclk          = 1'b0;
  logic                                presetn       = 1'b0;
  logic                                psel          = 1'b0;
  logic                                penable       = 1'b0;
  logic                                pwrite        = 1'b0;
  logic [rvr_pkg::ADDR_W-1:0]          paddr         = '0;
  logic [31:0]                         pwdata        = '0;
  logic                                power_down    = 1'b0;
  logic                                seq_periph_on = 1'b0;
  logic                                seq_mem_on    = 1'b0;
  logic [31:0]                         prdata;
  logic                                pready;
  logic                                pslverr;
  logic [rvr_pkg::NRAIL-1:0][5:0]      rail_code;
  logic [2:0]                          buck_pwm_force;
  rvr_pkg::rvr_ldo_ten_out_t           ldo_ten_out;
  logic                                periph_switch_pin;
  logic                                memory_switch_pin;
  int                                  err_count = 0;
  int                                  compares  = 0;
  logic [31:0]                         q;
  logic                                e;
  logic [5:0]                          c;
  logic [5:0]                          t;
  logic [5:0]                          cur;
  logic [7:0]                          corner [4] = '{8'h00, 8'h30, 8'h31, 8'h3F};

  rvr_regs #(.STEP_CYC(STEP)) rvr_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down(power_down), .seq_periph_on(seq_periph_on), .seq_mem_on(seq_mem_on),
    .rail_code(rail_code), .buck_pwm_force(buck_pwm_force), .ldo_ten_out(ldo_ten_out),
    .periph_switch_pin(periph_switch_pin), .memory_switch_pin(memory_switch_pin)
  );

  always #50 pclk = ~pclk;

  function automatic logic [5:0] code_of(input logic [5:0] k);
    return (k > 6'h30) ? 6'h30 : k;
  endfunction

  function automatic logic [11:0] mv_of(input logic [5:0] k);
    return 12'h4B0 + 12'h032 * {6'h00, code_of(k)};
  endfunction

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("apb_ready", 32'h0, 32'h1);
  endtask

  task automatic wait_go(input int r);
    for (int n = 0; n < 200; n++) begin
      apb(1'b0, 12'h0F0, 32'h0);
      if (q[r] === 1'b0) break;
    end
    chk("go_cleared", q[r], 1'b0);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #2000000;
    err_count++;
    close_out();
  end

  initial begin
    void'($urandom(11891));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and unmapped access
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, (i < 5) ? 12'(12'h0C0 + 4 * i) : ((i == 5) ? 12'h0EC : 12'h0F0), 32'h0);
      chk("reset_value", q, 32'h0);
    end
    chk("ldo_rst_out", {13'h0, ldo_ten_out}, {13'h0, 1'b0, 6'h00, 12'h4B0});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    chk("unmapped_data", q, 32'h0);
    $display("test reset done");
    // Tenth LDO immediate codes incl. saturation
    for (int i = 0; i < 8; i++) begin
      c = (i < 4) ? corner[i][5:0] : 6'($urandom_range(0, 63));
      apb(1'b1, 12'h0EC, {24'h0, 2'b01, c});
      apb(1'b0, 12'h0EC, 32'h0);
      chk("ldo_readback", q, {24'h0, 2'b01, c});
      chk("ldo_out", {13'h0, ldo_ten_out}, {13'h0, 1'b1, code_of(c), mv_of(c)});
    end
    apb(1'b1, 12'h0EC, {24'h0, 2'b00, c});
    apb(1'b0, 12'h0EC, 32'h0);
    chk("ldo_off", {31'h0, ldo_ten_out.on}, 32'h0);
    // Preset held until power-down
    apb(1'b1, 12'h0EC, 32'h00000050);
    apb(1'b1, 12'h0EC, 32'h000000E0);
    apb(1'b0, 12'h0EC, 32'h0);
    chk("preset_hold", {26'h0, ldo_ten_out.code}, 32'h10);
    power_down <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("preset_apply", {13'h0, ldo_ten_out}, {13'h0, 1'b1, 6'h20, mv_of(6'h20)});
    apb(1'b1, 12'h0EC, 32'h00000050);
    apb(1'b0, 12'h0EC, 32'h0);
    chk("pd_disable", {31'h0, ldo_ten_out.on}, 32'h0);
    power_down <= 1'b0;
    $display("test ldo_ten done");
    // Ramp every rail with blocked writes in flight
    for (int r = 0; r < 5; r++) begin
      cur = rail_code[r];
      t = {~cur[5], cur[4], 4'($urandom)};
      apb(1'b1, 12'(12'h0C0 + 4 * r), {26'h0, t});
      apb(1'b1, 12'h0F0, 32'(1 << r));
      @(posedge pclk);
      if (r < 3) chk("pwm_force", {29'h0, buck_pwm_force}, 32'(1 << r));
      apb(1'b1, 12'(12'h0C0 + 4 * r), {26'h0, ~t});
      apb(1'b0, 12'(12'h0C0 + 4 * r), 32'h0);
      chk("blocked_write", q, {26'h0, t});
      if (r == 0) begin
        apb(1'b1, 12'h0C4, 32'h0000003F);
        apb(1'b0, 12'h0C4, 32'h0);
        chk("core_blocks_proc", q, 32'h0);
      end
      wait_go(r);
      chk("rail_target", {26'h0, rail_code[r]}, {26'h0, t});
      chk("pwm_release", {29'h0, buck_pwm_force}, 32'h0);
    end
    // Second and third LDO go ignored under preset
    cur = rail_code[3];
    t = rail_code[4];
    apb(1'b1, 12'h0CC, {24'h0, 2'b10, ~cur});
    apb(1'b1, 12'h0D0, {24'h0, 2'b10, ~t});
    apb(1'b1, 12'h0F0, 32'h18);
    apb(1'b0, 12'h0F0, 32'h0);
    chk("preset_go_ignored", q, 32'h0);
    repeat (10) @(posedge pclk);
    chk("preset_rail_hold", {26'h0, rail_code[3]}, {26'h0, cur});
    chk("preset_rail4_hold", {26'h0, rail_code[4]}, {26'h0, t});
    $display("test ramp done");
    // Switch enables against sequencer requests
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 12'h0F0, {25'h0, i[1], i[0], 5'h00});
      seq_periph_on <= i[2];
      seq_mem_on <= i[3];
      repeat (3) @(posedge pclk);
      chk("periph_pin", {31'h0, periph_switch_pin}, {31'h0, i[0] & i[2]});
      chk("mem_pin", {31'h0, memory_switch_pin}, {31'h0, i[1] & i[3]});
    end
    $display("test switches done");
    // Voltage lock: codes frozen, enables and ramps still work
    t = ~rail_code[2];
    apb(1'b1, 12'h0C8, {26'h0, t});
    apb(1'b1, 12'h0F0, 32'h80);
    apb(1'b1, 12'h0C8, {26'h0, ~t});
    apb(1'b0, 12'h0C8, 32'h0);
    chk("lock_code", q, {26'h0, t});
    apb(1'b1, 12'h0EC, 32'h0000007F);
    apb(1'b0, 12'h0EC, 32'h0);
    chk("lock_enable", q, 32'h50);
    apb(1'b1, 12'h0F0, 32'h84);
    wait_go(2);
    chk("lock_ramp", {26'h0, rail_code[2]}, {26'h0, t});
    $display("test lock done");
    close_out();
  end
endmodule
`default_nettype wire
